/* pmon_top.sv */
// performance monitor: two control registers, their user mirrors, four event counters
// assumes special register moves arrive as one-cycle strobes and events are synchronous
// What this block does
// - user mirror of control zero at number 936 reads its live contents
// - control one holds counter three and four 5-bit event selectors
// - control one read and written at number 956; lower bits reserved
// - user mirror of control one at number 940 reads its live contents
// - four independent 32-bit counters, each may request an overflow interrupt
// - top bit is the overflow flag, lower bits hold the count
// - counter counts as overflowed once its top bit is one
// - interrupt needs global enable and the matching overflow enable: counter one's own, or the one shared by counters two to four
// - condition may stand masked; exception taken once external enable is set
// - stop-on-interrupt freezes all counters while an interrupt is signalled
// - software should load counters with top bit clear, else spurious interrupt
// - counting runs while a selection is written, until cleared or, with stop-on-interrupt set, an interrupt
// - counter one codes: hold, every cycle, completed instructions
// - counter one code three counts rising edges of a chosen time base bit
// - counter one codes: dispatched, in-order I/O done, translation search cycles
// - counter one codes: level-two hits, fetch addresses, breakpoint matches
// - counter one code ten counts load misses above the latency threshold
// - counter one codes: unresolved branches, branch stalls, instruction cache misses
// - other counter one codes are reserved and count nothing
// - counter two codes: hold, every cycle, completed instructions
// - global interrupt enable clears itself when the interrupt is taken
// - counter one enable at bit 16, shared enable at bit 17
`default_nettype none
`include "pmon_params.svh"
module pmon_top (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire pmon_pkg::pmon_spr_t spr_num_i,
    input wire logic spr_wr_i,
    input wire logic spr_rd_i,
    input wire pmon_pkg::pmon_word_t spr_wdata_i,
    input wire logic external_irq_enable_i,
    input wire logic [31:0] tb_lower_i,
    input wire logic [1:0] ev_instr_done_i,
    input wire logic [1:0] ev_dispatch_i,
    input wire logic ev_io_order_done_i,
    input wire logic ev_xlate_search_i,
    input wire logic ev_l2_hit_i,
    input wire logic ev_iea_valid_i,
    input wire logic ev_bkpt_match_i,
    input wire logic ev_l1d_load_miss_i,
    input wire logic [7:0] l1d_miss_latency_i,
    input wire logic ev_branch_unresolved_i,
    input wire logic ev_branch_stall_i,
    input wire logic ev_l1i_miss_i,
    output logic [31:0] spr_rdata_o,
    output logic spr_rd_valid_o,
    output logic pm_irq_o,
    output logic pm_exception_o
);
    import pmon_pkg::*;

    pmon_word_t ctrl0_reg;
    pmon_word_t ctrl0_next;
    pmon_word_t ctrl1_reg;
    pmon_word_t ctrl1_next;
    pmon_word_t rdata_reg;
    pmon_word_t rdata_next;
    logic rd_valid_reg;
    logic rd_valid_next;
    logic tb_bit_reg;
    logic tb_bit_next;
    pmon_irq_e irq_state_reg;
    pmon_irq_e irq_state_next;
    logic exc_reg;
    logic exc_next;
    logic irq_reg;
    logic irq_next;

    logic [31:0] cnt [`PMON_NUM_CNT];
    logic [`PMON_NUM_CNT-1:0] cnt_load;
    pmon_inc_t cnt_inc [`PMON_NUM_CNT];
    logic [5:0] sel_x [`PMON_NUM_CNT];
    pmon_spr_t cnt_spr [`PMON_NUM_CNT];

    logic tb_bit;
    logic tb_rise;
    logic irq_cond;
    logic irq_take;
    logic freeze;
    logic [6:0] sel1;
    logic [5:0] thr;

    assign sel1 = ctrl0_reg[`PMON_C0_SEL1_HI:`PMON_C0_SEL1_LO];
    assign thr = ctrl0_reg[`PMON_C0_THR_HI:`PMON_C0_THR_LO];
    assign sel_x[0] = 6'h00;
    assign sel_x[1] = ctrl0_reg[`PMON_C0_SEL2_HI:`PMON_C0_SEL2_LO];
    assign sel_x[2] = {1'b0, ctrl1_reg[`PMON_C1_SEL3_HI:`PMON_C1_SEL3_LO]};
    assign sel_x[3] = {1'b0, ctrl1_reg[`PMON_C1_SEL4_HI:`PMON_C1_SEL4_LO]};
    assign cnt_spr[0] = `PMON_SPR_CNT1;
    assign cnt_spr[1] = `PMON_SPR_CNT2;
    assign cnt_spr[2] = `PMON_SPR_CNT3;
    assign cnt_spr[3] = `PMON_SPR_CNT4;

    // time base bit select and rising edge
    always_comb begin
        unique case (ctrl0_reg[`PMON_C0_TB_SEL_HI:`PMON_C0_TB_SEL_LO])
            2'b00: tb_bit = tb_lower_i[`PMON_TB_BIT_SEL0];
            2'b01: tb_bit = tb_lower_i[`PMON_TB_BIT_SEL1];
            2'b10: tb_bit = tb_lower_i[`PMON_TB_BIT_SEL2];
            2'b11: tb_bit = tb_lower_i[`PMON_TB_BIT_SEL3];
        endcase
        tb_bit_next = tb_bit;
        // changing the select can fake one edge; accepted, software reprograms rarely
        tb_rise = tb_bit && !tb_bit_reg;
    end

    // overflow interrupt condition; level form keeps it pending while masked
    always_comb begin
        irq_cond = ctrl0_reg[`PMON_C0_GLOBAL_IE]
            && ((ctrl0_reg[`PMON_C0_CNT1_IE] && cnt[0][`PMON_OVF_BIT])
            || (ctrl0_reg[`PMON_C0_CNTX_IE] && (cnt[1][`PMON_OVF_BIT]
            || cnt[2][`PMON_OVF_BIT] || cnt[3][`PMON_OVF_BIT])));
        irq_take = irq_cond && external_irq_enable_i;
        irq_next = irq_cond;
        freeze = ctrl0_reg[`PMON_C0_STOP_ON_IRQ] && irq_cond;
        exc_next = irq_take;
        if (irq_take) begin
            irq_state_next = PMON_IRQ_TAKEN;
        end else if (irq_cond) begin
            irq_state_next = PMON_IRQ_PEND;
        end else begin
            irq_state_next = PMON_IRQ_IDLE;
        end
    end

    // per-counter event choice and the counter itself
    genvar gi;
    generate
        for (gi = 0; gi < `PMON_NUM_CNT; gi++) begin : g_cnt
            always_comb begin
                cnt_load[gi] = spr_wr_i && (spr_num_i == cnt_spr[gi]);
                cnt_inc[gi] = `PMON_INC_ZERO;
                if (gi == 0) begin
                    // unknown codes fall to zero increment
                    case (sel1)
                        PMON_S1_HOLD: cnt_inc[gi] = `PMON_INC_ZERO;
                        PMON_S1_CYCLES: cnt_inc[gi] = `PMON_INC_ONE;
                        PMON_S1_INSTR_DONE: cnt_inc[gi] = ev_instr_done_i;
                        PMON_S1_TB_EDGE: cnt_inc[gi] = {1'b0, tb_rise};
                        PMON_S1_DISPATCH: cnt_inc[gi] = ev_dispatch_i;
                        PMON_S1_IO_ORDER: cnt_inc[gi] = {1'b0, ev_io_order_done_i};
                        PMON_S1_XLATE_SEARCH: cnt_inc[gi] = {1'b0, ev_xlate_search_i};
                        PMON_S1_L2_HIT: cnt_inc[gi] = {1'b0, ev_l2_hit_i};
                        PMON_S1_IEA_VALID: cnt_inc[gi] = {1'b0, ev_iea_valid_i};
                        PMON_S1_BKPT_MATCH: cnt_inc[gi] = {1'b0, ev_bkpt_match_i};
                        PMON_S1_LOAD_MISS_THR: cnt_inc[gi] =
                            {1'b0, ev_l1d_load_miss_i && (l1d_miss_latency_i > {2'h0, thr})};
                        PMON_S1_BR_UNRESOLVED: cnt_inc[gi] = {1'b0, ev_branch_unresolved_i};
                        PMON_S1_BR_STALL: cnt_inc[gi] = {1'b0, ev_branch_stall_i};
                        PMON_S1_L1I_MISS: cnt_inc[gi] = {1'b0, ev_l1i_miss_i};
                        default: cnt_inc[gi] = `PMON_INC_ZERO;
                    endcase
                end else begin
                    case (sel_x[gi])
                        PMON_SX_HOLD: cnt_inc[gi] = `PMON_INC_ZERO;
                        PMON_SX_CYCLES: cnt_inc[gi] = `PMON_INC_ONE;
                        PMON_SX_INSTR_DONE: cnt_inc[gi] = ev_instr_done_i;
                        PMON_SX_TB_EDGE: cnt_inc[gi] = {1'b0, tb_rise};
                        PMON_SX_DISPATCH: cnt_inc[gi] = ev_dispatch_i;
                        default: cnt_inc[gi] = `PMON_INC_ZERO;
                    endcase
                end
                if (freeze) begin
                    cnt_inc[gi] = `PMON_INC_ZERO;
                end
            end

            pmon_counter u_cnt (
                .mclk_i(mclk_i),
                .rstn_i(rstn_i),
                .load_i(cnt_load[gi]),
                .load_data_i(spr_wdata_i),
                .inc_i(cnt_inc[gi]),
                .count_o(cnt[gi])
            );
        end
    endgenerate

    // control registers
    always_comb begin
        ctrl0_next = ctrl0_reg;
        ctrl1_next = ctrl1_reg;
        if (spr_wr_i && spr_num_i == `PMON_SPR_CTRL0) begin
            ctrl0_next = spr_wdata_i;
        end else if (irq_take) begin
            // a software write in the take cycle wins so a re-arm is never lost
            ctrl0_next[`PMON_C0_GLOBAL_IE] = 1'b0;
        end
        if (spr_wr_i && spr_num_i == `PMON_SPR_CTRL1) begin
            ctrl1_next = spr_wdata_i & `PMON_C1_WMASK;
        end
    end

    // read port: one cycle after the strobe
    always_comb begin
        rd_valid_next = spr_rd_i;
        rdata_next = `PMON_RDATA_NONE;
        if (spr_rd_i) begin
            unique case (spr_num_i)
                `PMON_SPR_CTRL0: rdata_next = ctrl0_reg;
                `PMON_SPR_UCTRL0: rdata_next = ctrl0_reg;
                `PMON_SPR_CTRL1: rdata_next = ctrl1_reg;
                `PMON_SPR_UCTRL1: rdata_next = ctrl1_reg;
                `PMON_SPR_CNT1: rdata_next = cnt[0];
                `PMON_SPR_CNT2: rdata_next = cnt[1];
                `PMON_SPR_CNT3: rdata_next = cnt[2];
                `PMON_SPR_CNT4: rdata_next = cnt[3];
                default: rdata_next = `PMON_RDATA_NONE;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            ctrl0_reg <= `PMON_CTRL_RESET;
            ctrl1_reg <= `PMON_CTRL_RESET;
            rdata_reg <= `PMON_RDATA_NONE;
            rd_valid_reg <= 1'b0;
            tb_bit_reg <= 1'b0;
            irq_state_reg <= PMON_IRQ_IDLE;
            exc_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            ctrl0_reg <= ctrl0_next;
            ctrl1_reg <= ctrl1_next;
            rdata_reg <= rdata_next;
            rd_valid_reg <= rd_valid_next;
            tb_bit_reg <= tb_bit_next;
            irq_state_reg <= irq_state_next;
            exc_reg <= exc_next;
            irq_reg <= irq_next;
        end
    end

    assign spr_rdata_o = rdata_reg;
    assign spr_rd_valid_o = rd_valid_reg;
    assign pm_irq_o = irq_reg;
    assign pm_exception_o = exc_reg;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_rd_mirror0;
        spr_rd_i && spr_num_i == `PMON_SPR_UCTRL0;
    endsequence
    sequence s_rd_mirror1;
        spr_rd_i && spr_num_i == `PMON_SPR_UCTRL1;
    endsequence
    sequence s_ovf_enabled;
        ctrl0_reg[`PMON_C0_GLOBAL_IE] && ctrl0_reg[`PMON_C0_CNT1_IE] && cnt[0][`PMON_OVF_BIT];
    endsequence
    sequence s_wr_ctrl1;
        spr_wr_i && spr_num_i == `PMON_SPR_CTRL1;
    endsequence
    sequence s_sel1_tb_edge;
        sel1 == PMON_S1_TB_EDGE && tb_rise && !freeze && !cnt_load[0];
    endsequence

    a_mirror_zero: assert property (s_rd_mirror0 |=> spr_rd_valid_o && spr_rdata_o == $past(ctrl0_reg))
        else $error("user mirror zero differs from control zero");
    a_mirror_one: assert property (s_rd_mirror1 |=> spr_rdata_o == $past(ctrl1_reg))
        else $error("user mirror one differs from control one");
    a_ctrl1_resv: assert property ((ctrl1_reg & ~`PMON_C1_WMASK) == 32'h0)
        else $error("reserved control one bits not zero");
    a_irq_gate: assert property (!ctrl0_reg[`PMON_C0_GLOBAL_IE] |=> !pm_irq_o)
        else $error("interrupt raised without global enable");
    a_irq_raise: assert property (s_ovf_enabled |=> pm_irq_o)
        else $error("enabled overflow did not raise interrupt");
    a_exc_masked: assert property (pm_exception_o |-> $past(external_irq_enable_i))
        else $error("exception taken while external interrupts masked");
    a_monitor_irq_global_enable_clear: assert property (s_ovf_enabled ##0 external_irq_enable_i ##0 !spr_wr_i
        |=> !ctrl0_reg[`PMON_C0_GLOBAL_IE] && pm_exception_o ##1 !pm_exception_o)
        else $error("global enable not cleared when interrupt taken");
    a_freeze_hold: assert property (freeze && !cnt_load[0] |=> $stable(cnt[0]))
        else $error("counter moved while frozen");
    a_cycle_count: assert property (sel1 == PMON_S1_CYCLES && !freeze && !cnt_load[0]
        |=> cnt[0] == $past(cnt[0]) + 32'h1)
        else $error("cycle code did not add one");
    a_hold_code: assert property (sel1 == PMON_S1_HOLD && !cnt_load[0] |=> $stable(cnt[0]))
        else $error("hold code changed counter");
    a_rd_valid_pulse: assert property (spr_rd_i |=> spr_rd_valid_o)
        else $error("read strobe not answered next cycle");
    a_rd_idle_zero: assert property (!spr_rd_i |=> !spr_rd_valid_o && spr_rdata_o == `PMON_RDATA_NONE)
        else $error("read port not idle without strobe");
    a_ctrl1_write: assert property (s_wr_ctrl1 |=> ctrl1_reg == ($past(spr_wdata_i) & `PMON_C1_WMASK))
        else $error("control one write not masked to selector fields");
    a_mirror_ro: assert property (spr_wr_i && spr_num_i == `PMON_SPR_UCTRL1 |=> $stable(ctrl1_reg))
        else $error("user mirror one accepted a write");
    a_tb_edge: assert property (s_sel1_tb_edge |=> cnt[0] == $past(cnt[0]) + 32'h1)
        else $error("time base rise not counted");
    a_resv_code: assert property (sel1 > PMON_S1_L1I_MISS && !cnt_load[0] |=> $stable(cnt[0]))
        else $error("reserved code changed counter");
    a_sel2_cycles: assert property (sel_x[1] == PMON_SX_CYCLES && !freeze && !cnt_load[1]
        |=> cnt[1] == $past(cnt[1]) + 32'h1)
        else $error("counter two cycle code did not add one");
    a_irq_drop: assert property (!irq_cond |=> !pm_irq_o)
        else $error("interrupt stands without condition");
    a_pend_masked: assert property (irq_cond && !external_irq_enable_i
        |=> irq_state_reg == PMON_IRQ_PEND && pm_irq_o && !pm_exception_o)
        else $error("masked condition not held pending");
    a_taken_state: assert property ((irq_state_reg == PMON_IRQ_TAKEN) == pm_exception_o)
        else $error("taken state and exception pulse disagree");
endmodule
`default_nettype wire

/* pmon_params.svh */
// constants of the performance monitor: register numbers, field positions, reset values
// assumes big-endian bit n of the register view maps to bit 31-n of a vector
`ifndef PMON_PARAMS_SVH
`define PMON_PARAMS_SVH

`define PMON_SPR_CTRL0 10'h3B8
`define PMON_SPR_UCTRL0 10'h3A8
`define PMON_SPR_CTRL1 10'h3BC
`define PMON_SPR_UCTRL1 10'h3AC
`define PMON_SPR_CNT1 10'h3B9
`define PMON_SPR_CNT2 10'h3BA
`define PMON_SPR_CNT3 10'h3BD
`define PMON_SPR_CNT4 10'h3BE

`define PMON_CTRL_RESET 32'h0000_0000
`define PMON_CNT_RESET 32'h0000_0000
`define PMON_RDATA_NONE 32'h0000_0000

// control zero fields
`define PMON_C0_GLOBAL_IE 26
`define PMON_C0_STOP_ON_IRQ 25
`define PMON_C0_TB_SEL_HI 24
`define PMON_C0_TB_SEL_LO 23
`define PMON_C0_THR_HI 21
`define PMON_C0_THR_LO 16
`define PMON_C0_CNT1_IE 15
`define PMON_C0_CNTX_IE 14
`define PMON_C0_SEL1_HI 12
`define PMON_C0_SEL1_LO 6
`define PMON_C0_SEL2_HI 5
`define PMON_C0_SEL2_LO 0

// control one fields
`define PMON_C1_SEL3_HI 31
`define PMON_C1_SEL3_LO 27
`define PMON_C1_SEL4_HI 26
`define PMON_C1_SEL4_LO 22
`define PMON_C1_WMASK 32'hFFC0_0000

// counter overflow flag
`define PMON_OVF_BIT 31

// time base lower bit picked by the two-bit select
`define PMON_TB_BIT_SEL0 16
`define PMON_TB_BIT_SEL1 12
`define PMON_TB_BIT_SEL2 8
`define PMON_TB_BIT_SEL3 0

`define PMON_NUM_CNT 4
`define PMON_INC_ZERO 2'h0
`define PMON_INC_ONE 2'h1

`endif

/* pmon_pkg.sv */
// types shared by the performance monitor files
// assumes pmon_params.svh is included alongside
`default_nettype none
package pmon_pkg;
    typedef logic [9:0] pmon_spr_t;
    typedef logic [31:0] pmon_word_t;
    typedef logic [1:0] pmon_inc_t;

    // counter one event codes
    typedef enum logic [6:0] {
        PMON_S1_HOLD = 7'h00,
        PMON_S1_CYCLES = 7'h01,
        PMON_S1_INSTR_DONE = 7'h02,
        PMON_S1_TB_EDGE = 7'h03,
        PMON_S1_DISPATCH = 7'h04,
        PMON_S1_IO_ORDER = 7'h05,
        PMON_S1_XLATE_SEARCH = 7'h06,
        PMON_S1_L2_HIT = 7'h07,
        PMON_S1_IEA_VALID = 7'h08,
        PMON_S1_BKPT_MATCH = 7'h09,
        PMON_S1_LOAD_MISS_THR = 7'h0A,
        PMON_S1_BR_UNRESOLVED = 7'h0B,
        PMON_S1_BR_STALL = 7'h0C,
        PMON_S1_L1I_MISS = 7'h0D
    } pmon_sel1_e;

    // codes shared by counters two to four
    typedef enum logic [5:0] {
        PMON_SX_HOLD = 6'h00,
        PMON_SX_CYCLES = 6'h01,
        PMON_SX_INSTR_DONE = 6'h02,
        PMON_SX_TB_EDGE = 6'h03,
        PMON_SX_DISPATCH = 6'h04
    } pmon_selx_e;

    // interrupt signalling state
    typedef enum logic [1:0] {
        PMON_IRQ_IDLE = 2'b00,
        PMON_IRQ_PEND = 2'b01,
        PMON_IRQ_TAKEN = 2'b10
    } pmon_irq_e;
endpackage
`default_nettype wire

/* pmon_counter.sv */
// one 32-bit event counter: software load or hardware add
// assumes the caller gates the increment for freeze and hold codes
`default_nettype none
`include "pmon_params.svh"
module pmon_counter (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic load_i,
    input wire pmon_pkg::pmon_word_t load_data_i,
    input wire pmon_pkg::pmon_inc_t inc_i,
    output logic [31:0] count_o
);
    import pmon_pkg::*;

    pmon_word_t count_reg;
    pmon_word_t count_next;

    always_comb begin
        // a load beats a same-cycle event so software sees exactly what it wrote
        if (load_i) begin
            count_next = load_data_i;
        end else begin
            count_next = count_reg + {30'h0, inc_i};
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            count_reg <= `PMON_CNT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count_o = count_reg;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    a_load_value: assert property (load_i |=> count_reg == $past(load_data_i))
        else $error("counter did not take loaded value");
    a_add_step: assert property (!load_i |=> count_reg == $past(count_reg) + {30'h0, $past(inc_i)})
        else $error("counter step differs from increment");
endmodule
`default_nettype wire

/* pmon_src_model.sv */
// event source model: pipeline event lines and the time base lower word
// assumes the bench calls burst just after a rising clock edge
`default_nettype none
module pmon_src_model (
    input wire logic mclk_i,
    output logic [31:0] tb_lower_o,
    output logic [1:0] done_o,
    output logic [1:0] disp_o,
    output logic [8:0] ev_o,
    output logic [7:0] lat_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        tb_lower_o = 32'h0;
        done_o = 2'h0;
        disp_o = 2'h0;
        ev_o = 9'h0;
        lat_o = 8'h0;
    end
    // idx 0 completions, 1 dispatches, 2..10 single lines, 11 time base bit v, others idle
    // pairs arrive as the value two, the most the core reports in a cycle
    task automatic burst(input int idx, input int k, input int v);
        if (idx == 11) begin
            for (int i = 0; i < 2 * k; i++) begin
                tb_lower_o[v] = ~tb_lower_o[v];
                @(posedge mclk_i);
                #1;
            end
        end else begin
            if (idx == 0) done_o = 2'h2;
            if (idx == 1) disp_o = 2'h2;
            if (idx > 1 && idx < 11) ev_o[idx - 2] = 1'b1;
            lat_o = 8'(v);
            repeat (k) @(posedge mclk_i);
            #1;
            done_o = 2'h0;
            disp_o = 2'h0;
            ev_o = 9'h0;
            // latency only qualifies a miss, so it is scrambled between misses
            lat_o = ~lat_o;
        end
    endtask
endmodule
`default_nettype wire

/* pmon_top_tb_top.sv */
// self-checking bench for the performance monitor: register moves, event codes, overflow interrupt
// assumes pmon_src_model drives every event line; stimulus lands 1 ns after each rising edge
`default_nettype none
`include "pmon_params.svh"
module pmon_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int K = 5;
    localparam logic [31:0] GIE = 32'h1 << `PMON_C0_GLOBAL_IE;
    localparam logic [31:0] STOP = 32'h1 << `PMON_C0_STOP_ON_IRQ;
    localparam logic [31:0] IE1 = 32'h1 << `PMON_C0_CNT1_IE;
    localparam logic [31:0] IEX = 32'h1 << `PMON_C0_CNTX_IE;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [9:0] spr_num = 10'h0;
    logic spr_wr = 1'b0;
    logic spr_rd = 1'b0;
    logic [31:0] spr_wdata = 32'h0;
    logic ext_en = 1'b0;
    logic [31:0] tb_lower, rdata;
    logic [1:0] done, disp;
    logic [8:0] ev;
    logic [7:0] lat;
    logic rd_valid, irq, exc;
    int n_errors = 0;
    int total_checks = 0;

    always #25 mclk = ~mclk;

    pmon_src_model i_src (.mclk_i(mclk), .tb_lower_o(tb_lower), .done_o(done), .disp_o(disp), .ev_o(ev),
        .lat_o(lat));
    pmon_top i_dut (.mclk_i(mclk), .rstn_i(rstn), .spr_num_i(spr_num), .spr_wr_i(spr_wr), .spr_rd_i(spr_rd),
        .spr_wdata_i(spr_wdata), .external_irq_enable_i(ext_en), .tb_lower_i(tb_lower),
        .ev_instr_done_i(done), .ev_dispatch_i(disp), .ev_io_order_done_i(ev[0]), .ev_xlate_search_i(ev[1]),
        .ev_l2_hit_i(ev[2]), .ev_iea_valid_i(ev[3]), .ev_bkpt_match_i(ev[4]), .ev_l1d_load_miss_i(ev[5]),
        .l1d_miss_latency_i(lat), .ev_branch_unresolved_i(ev[6]), .ev_branch_stall_i(ev[7]),
        .ev_l1i_miss_i(ev[8]), .spr_rdata_o(rdata), .spr_rd_valid_o(rd_valid), .pm_irq_o(irq),
        .pm_exception_o(exc));

    task automatic wrap_up();
        if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge mclk);
            #1;
        end
    endtask

    task automatic wr(input logic [9:0] num, input logic [31:0] d);
        tick(1);
        spr_num = num;
        spr_wdata = d;
        spr_wr = 1'b1;
        tick(1);
        spr_wr = 1'b0;
        spr_wdata = ~d;
    endtask

    // read answers exactly one cycle after the strobe
    task automatic rchk(input logic [9:0] num, input logic [31:0] exp);
        tick(1);
        spr_num = num;
        spr_rd = 1'b1;
        tick(1);
        spr_rd = 1'b0;
        check("read valid", {31'h0, rd_valid}, 32'h1);
        check($sformatf("spr %h", num), rdata, exp);
    endtask

    // clear counter, select, let the source fire K times, deselect, read back
    task automatic run(input logic [9:0] creg, input logic [31:0] cval, input logic [9:0] cnt,
        input int idx, input int v, input logic [31:0] exp);
        wr(cnt, 32'h0);
        wr(creg, cval);
        i_src.burst(idx, K, v);
        wr(creg, 32'h0);
        rchk(cnt, exp);
    endtask

    task automatic s_regs();
        logic [9:0] regs [8] = '{`PMON_SPR_CTRL0, `PMON_SPR_UCTRL0, `PMON_SPR_CTRL1, `PMON_SPR_UCTRL1,
            `PMON_SPR_CNT1, `PMON_SPR_CNT2, `PMON_SPR_CNT3, `PMON_SPR_CNT4};
        foreach (regs[i]) rchk(regs[i], 32'h0);
        wr(`PMON_SPR_CTRL1, 32'hFFFF_FFFF);
        rchk(`PMON_SPR_CTRL1, 32'hFFC0_0000);
        wr(`PMON_SPR_UCTRL1, 32'h0);
        rchk(`PMON_SPR_UCTRL1, 32'hFFC0_0000);
        wr(`PMON_SPR_CTRL0, 32'h0123_8000);
        wr(`PMON_SPR_UCTRL0, 32'h0);
        rchk(`PMON_SPR_UCTRL0, 32'h0123_8000);
        wr(`PMON_SPR_CTRL1, 32'h0);
        wr(`PMON_SPR_CTRL0, 32'h0);
        wr(10'h3FF, 32'h1234_5678);
        rchk(10'h3FF, 32'h0);
    endtask

    task automatic s_codes();
        int tbb [4] = '{`PMON_TB_BIT_SEL0, `PMON_TB_BIT_SEL1, `PMON_TB_BIT_SEL2, `PMON_TB_BIT_SEL3};
        logic [31:0] thr;
        thr = 32'h5 << `PMON_C0_THR_LO;
        // cycle count covers the edges after the select edge through the deselect edge
        run(`PMON_SPR_CTRL0, 32'h0, `PMON_SPR_CNT1, 0, 0, 32'h0);
        run(`PMON_SPR_CTRL0, 32'h1 << 6, `PMON_SPR_CNT1, 12, 0, K + 2);
        run(`PMON_SPR_CTRL0, 32'h2 << 6, `PMON_SPR_CNT1, 0, 0, 2 * K);
        for (int s = 0; s < 4; s++)
            run(`PMON_SPR_CTRL0, (32'h3 << 6) | (32'(s) << 23), `PMON_SPR_CNT1, 11, tbb[s], K);
        run(`PMON_SPR_CTRL0, 32'h4 << 6, `PMON_SPR_CNT1, 1, 0, 2 * K);
        for (int c = 5; c < 14; c++)
            run(`PMON_SPR_CTRL0, thr | (32'(c) << 6), `PMON_SPR_CNT1, c - 3, 6, K);
        run(`PMON_SPR_CTRL0, thr | (32'hA << 6), `PMON_SPR_CNT1, 7, 5, 32'h0);
        run(`PMON_SPR_CTRL0, 32'hE << 6, `PMON_SPR_CNT1, 0, 0, 32'h0);
        run(`PMON_SPR_CTRL0, 32'h0, `PMON_SPR_CNT2, 0, 0, 32'h0);
        run(`PMON_SPR_CTRL0, 32'h1, `PMON_SPR_CNT2, 12, 0, K + 2);
        run(`PMON_SPR_CTRL0, 32'h2, `PMON_SPR_CNT2, 0, 0, 2 * K);
        run(`PMON_SPR_CTRL1, 32'h1 << 27, `PMON_SPR_CNT3, 12, 0, K + 2);
        run(`PMON_SPR_CTRL1, 32'h2 << 22, `PMON_SPR_CNT4, 0, 0, 2 * K);
    endtask

    task automatic s_irq();
        logic [9:0] cnts [3] = '{`PMON_SPR_CNT2, `PMON_SPR_CNT3, `PMON_SPR_CNT4};
        int n;
        n = 0;
        wr(`PMON_SPR_CNT2, 32'h100);
        wr(`PMON_SPR_CTRL0, GIE | STOP | IE1 | 32'h1);
        wr(`PMON_SPR_CNT1, 32'h8000_0000);
        tick(2);
        check("irq", {31'h0, irq}, 32'h1);
        check("exception", {31'h0, exc}, 32'h0);
        rchk(`PMON_SPR_CNT2, 32'h102);
        rchk(`PMON_SPR_CNT2, 32'h102);
        ext_en = 1'b1;
        while (exc !== 1'b1 && n < 8) begin
            tick(1);
            n++;
        end
        check("exception", {31'h0, exc}, 32'h1);
        if (exc !== 1'b1) wrap_up();
        tick(1);
        check("irq", {31'h0, irq}, 32'h0);
        rchk(`PMON_SPR_CTRL0, STOP | IE1 | 32'h1);
        ext_en = 1'b0;
        wr(`PMON_SPR_CNT1, 32'h7FFF_FFFE);
        wr(`PMON_SPR_CTRL0, GIE | IE1 | (32'h1 << 6));
        check("irq", {31'h0, irq}, 32'h0);
        tick(3);
        check("irq", {31'h0, irq}, 32'h1);
        wr(`PMON_SPR_CTRL0, GIE | IEX);
        tick(2);
        check("irq", {31'h0, irq}, 32'h0);
        wr(`PMON_SPR_CNT1, 32'h0);
        for (int i = 0; i < 3; i++) begin
            wr(cnts[i], 32'h8000_0000);
            tick(1);
            check("irq", {31'h0, irq}, 32'h1);
            wr(cnts[i], 32'h0);
            tick(1);
            check("irq", {31'h0, irq}, 32'h0);
        end
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        #1;
        rstn = 1'b1;
        s_regs();
        s_codes();
        s_irq();
        wrap_up();
    end
endmodule
`default_nettype wire
